/* File: verilog/ccoc_pkg.sv */
// Shared constants and types for the clamp control and output coding block
package ccoc_pkg;

  // Register byte offsets
  localparam logic [7:0] AddrCtrl   = 8'h00;
  localparam logic [7:0] AddrOffset = 8'h04;
  localparam logic [7:0] AddrGain   = 8'h08;
  localparam logic [7:0] AddrStatus = 8'h0C;
  localparam logic [7:0] AddrLast   = 8'h10;

  // Control word fields, least significant field last
  typedef struct packed {
    logic [3:0] clampDacCode;
    logic [1:0] monoChannel;
    logic [1:0] cycleIntervalSelect;
    logic       cycleVersusClampSource;
    logic       frameCycleEnable;
    logic       lineByLine;
    logic       outputPolarityInvert;
    logic [1:0] blackLevelPlacement;
    logic [1:0] resetSamplePosition;
    logic       internalClampSelect;
    logic       clampDacWideRange;
    logic       externalReferenceSelect;
    logic       doubleSamplingSelect;
  } ccoc_ctrl_type;

  localparam int CtrlW = $bits(ccoc_ctrl_type);
  localparam logic [19:0] CtrlReset   = 20'h0_0001;
  localparam logic [23:0] OffsetReset = 24'h80_8080;
  localparam logic [23:0] GainReset   = 24'h00_0000;

  // Status word bit positions
  localparam int StOverrun = 0;
  localparam int StChanLo  = 1;
  localparam int StArmed   = 3;
  localparam int StBusy    = 4;

  // One output word: channel tag and code
  typedef struct packed {
    logic [1:0]  channel;
    logic [15:0] code;
  } ccoc_word_type;

  localparam int WordW = $bits(ccoc_word_type);

  // Black-level placement codes
  localparam logic [1:0] PlaceBipolarA = 2'h0;
  localparam logic [1:0] PlaceBipolarB = 2'h1;
  localparam logic [1:0] PlaceNegative = 2'h2;
  localparam logic [1:0] PlacePositive = 2'h3;

  // Signal chain figures, voltages in microvolts
  localparam logic signed [47:0] OffsetSpanUv = 48'sd260000;
  localparam logic signed [47:0] OffsetMidX2  = 48'sd255;
  localparam logic signed [47:0] GainNum      = 48'sd208;
  localparam logic signed [47:0] GainBase     = 48'sd283;
  localparam logic signed [47:0] FullScaleUv  = 48'sd3000000;
  localparam logic signed [47:0] CodeMax      = 48'sd65535;
  localparam logic signed [47:0] CodeMid      = 48'sd32767;

  localparam int FifoDepth = 16;

endpackage : ccoc_pkg

/* File: verilog/clamp_control_and_output_coding.sv */
// Clamp timing, reference select, offset/gain coding, FIFO and AHB-Lite regs
`timescale 1ns/10ps
`default_nettype none

module ccoc_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign inReady = (count_q != (AW+1)'(DEPTH));
  assign push    = inValid && inReady;
  assign pop     = (count_q != '0) && (!outValid || outReady);

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) wrPtr_q <= wrPtr_q + 1'b1;
      if (pop)  rdPtr_q <= rdPtr_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= count_q + 1'b1;
    end else if (pop && !push) begin
      count_q <= count_q - 1'b1;
    end
  end

  // Output register, refilled from the array whenever it drains
  always_ff @(posedge core_clk) begin
    if (rst) begin
      outValid <= 1'b0;
      outData  <= '0;
    end else if (pop) begin
      outValid <= 1'b1;
      outData  <= mem[rdPtr_q];
    end else if (outReady) begin
      outValid <= 1'b0;
    end
  end
endmodule : ccoc_fifo

// Contract
// - Clamp pin level caught during each pixel-sync pulse arms next clamp.
// - Clamp pulse is built from core clock and pixel-sync input.
// - Clamp and reset-sample strobe sit at one of four positions.
// - Under auto-cycling the clamp follows the internal clamp-select bit.
// - Double sampling references reset level; otherwise reference pin level if external reference selected, else clamp DAC level.
// - Internal reference DAC drives pin unless external reference selected.
// - Four-bit clamp DAC code; range bit widens range and step.
// - Separate eight-bit offset and gain codes for three channels.
// - Offset adds 260 mV times (code minus 127.5) over 127.5.
// - Gain is 208 divided by (283 minus gain code).
// - Result scaled to 16-bit unsigned against 3 V full scale.
// - Bipolar placements add 32767 so zero input is mid-scale.
// - Positive-video placement adds nothing; black at code zero.
// - Negative-video placement adds 65535; black at top code.
// - Invert bit outputs 65535 minus code.
// - Line-by-line steps red, green, blue on pin pulses or by bits.
module clamp_control_and_output_coding
  import ccoc_pkg::*;
#(
  parameter int                 StepNarrowUv = 100000,
  parameter int                 StepWideUv   = 200000,
  parameter int                 BotNarrowUv  = 400000,
  parameter int                 BotWideUv    = 300000,
  parameter int                 DepthWords   = FifoDepth
) (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                pixelSampleSync,
  input  wire logic                clampOrCyclePin,
  input  wire logic signed [23:0]  videoLevel,
  input  wire logic signed [23:0]  resetLevel,
  input  wire logic signed [23:0]  referenceLevelPin,
  output logic                     clampPulse,
  output logic                     resetSampleStrobe,
  output logic                     clampLevelDacEnable,
  output logic signed [23:0]       clampLevelDacUv,
  output logic [1:0]               activeChannel,
  output logic                     outValid,
  input  wire logic                outReady,
  output logic [15:0]              outCode,
  output logic [1:0]               outChannel,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp
);

  ccoc_ctrl_type ctrl_q;
  logic [23:0]   offsetCodes_q;
  logic [23:0]   gainCodes_q;
  logic          overrun_q;
  logic [15:0]   lastCode_q;

  // Byte of a three-channel code word picked by channel
  function automatic logic [7:0] chanByte(input logic [23:0] w,
                                          input logic [1:0]  ch);
    unique case (ch)
      2'h1:    chanByte = w[15:8];
      2'h2:    chanByte = w[23:16];
      default: chanByte = w[7:0];
    endcase
  endfunction : chanByte

  // Offset, gain, conversion, placement, saturation and inversion
  function automatic logic [15:0] codeOf(input logic signed [31:0] v1,
                                         input logic [7:0]         dac,
                                         input logic [7:0]         pga,
                                         input logic [1:0]         place,
                                         input logic               inv);
    logic signed [47:0] offs;
    logic signed [47:0] v2;
    logic signed [47:0] v3;
    logic signed [47:0] d;
    logic [15:0]        c;
    offs = $signed({40'h00_0000_0000, dac}) * 48'sd2 - OffsetMidX2;
    v2   = 48'(v1) + (OffsetSpanUv * offs) / OffsetMidX2;
    v3   = (v2 * GainNum)
           / (GainBase - $signed({40'h00_0000_0000, pga}));
    d    = (v3 * CodeMax) / FullScaleUv;
    unique case (place)
      PlacePositive: d = d;
      PlaceNegative: d = d + CodeMax;
      default:       d = d + CodeMid;
    endcase
    if (d < 48'sd0) begin
      c = 16'h0000;
    end else if (d > CodeMax) begin
      c = 16'hFFFF;
    end else begin
      c = d[15:0];
    end
    codeOf = inv ? (16'hFFFF - c) : c;
  endfunction : codeOf

  // Pin synchronisers
  logic [1:0] syncPipe_q;
  logic [1:0] pinPipe_q;
  logic       syncPrev_q;
  logic       pinPrev_q;
  logic       sampleStrobe;
  logic       pinRise;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      syncPipe_q <= 2'h0;
      pinPipe_q  <= 2'h0;
      syncPrev_q <= 1'b0;
      pinPrev_q  <= 1'b0;
    end else begin
      syncPipe_q <= {syncPipe_q[0], pixelSampleSync};
      pinPipe_q  <= {pinPipe_q[0], clampOrCyclePin};
      syncPrev_q <= syncPipe_q[1];
      pinPrev_q  <= pinPipe_q[1];
    end
  end

  // Sample point is the first edge after the sync pulse falls
  assign sampleStrobe = syncPrev_q && !syncPipe_q[1];
  assign pinRise      = pinPipe_q[1] && !pinPrev_q;

  // Clamp source selection
  logic autoCycle;
  logic pinCapture_q;
  logic clampWanted;

  assign autoCycle   = ctrl_q.lineByLine && ctrl_q.cycleVersusClampSource;
  assign clampWanted = autoCycle ? ctrl_q.internalClampSelect
                                 : pinCapture_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pinCapture_q <= 1'b0;
    end else if (syncPipe_q[1]) begin
      pinCapture_q <= pinPipe_q[1];
    end
  end

  // Clamp and reset-sample placement after each sample point
  logic       clampArmed_q;
  logic       posRun_q;
  logic [1:0] posCnt_q;
  logic       posHit;

  assign posHit = posRun_q && (posCnt_q == ctrl_q.resetSamplePosition);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      clampArmed_q <= 1'b0;
      posRun_q     <= 1'b0;
      posCnt_q     <= 2'h0;
    end else if (sampleStrobe) begin
      clampArmed_q <= clampWanted;
      posRun_q     <= 1'b1;
      posCnt_q     <= 2'h0;
    end else if (posHit) begin
      posRun_q     <= 1'b0;
    end else if (posRun_q) begin
      posCnt_q     <= posCnt_q + 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      clampPulse        <= 1'b0;
      resetSampleStrobe <= 1'b0;
    end else begin
      clampPulse        <= posHit && clampArmed_q;
      resetSampleStrobe <= posHit;
    end
  end

  // Reference level DAC
  always_ff @(posedge core_clk) begin
    if (rst) begin
      clampLevelDacEnable <= 1'b0;
      clampLevelDacUv     <= 24'sh00_0000;
    end else begin
      clampLevelDacEnable <= !ctrl_q.externalReferenceSelect;
      clampLevelDacUv     <= ctrl_q.externalReferenceSelect ? 24'sh00_0000 :
        ctrl_q.clampDacWideRange
          ? 24'(StepWideUv * int'(ctrl_q.clampDacCode) + BotWideUv)
          : 24'(StepNarrowUv * int'(ctrl_q.clampDacCode) + BotNarrowUv);
    end
  end

  // Channel sequencing
  logic [1:0] cycleChannel_q;
  logic [1:0] chanNow;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cycleChannel_q <= 2'h0;
    end else if (!ctrl_q.lineByLine) begin
      cycleChannel_q <= 2'h0;
    end else if (autoCycle) begin
      if (ctrl_q.frameCycleEnable && pinRise) begin
        cycleChannel_q <= (cycleChannel_q == 2'h2) ? 2'h0
                                                   : cycleChannel_q + 2'h1;
      end
    end else begin
      cycleChannel_q <= (ctrl_q.cycleIntervalSelect == 2'h3) ? 2'h0
                        : ctrl_q.cycleIntervalSelect;
    end
  end

  assign chanNow = ctrl_q.lineByLine ? cycleChannel_q
                 : ((ctrl_q.monoChannel == 2'h3) ? 2'h0 : ctrl_q.monoChannel);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      activeChannel <= 2'h0;
    end else begin
      activeChannel <= chanNow;
    end
  end

  // Stage one: referenced input difference
  logic signed [31:0] v1_q;
  logic [1:0]         v1Chan_q;
  logic               v1Valid_q;
  logic signed [23:0] refLevel;
  logic               holdValid_q;
  ccoc_word_type      hold_q;
  logic               fifoReady;
  logic               holdTake;

  assign refLevel = ctrl_q.externalReferenceSelect ? referenceLevelPin
                                                   : clampLevelDacUv;
  assign holdTake = v1Valid_q && (!holdValid_q || fifoReady);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      v1Valid_q <= 1'b0;
      v1_q      <= 32'sh0000_0000;
      v1Chan_q  <= 2'h0;
    end else if (sampleStrobe && (!v1Valid_q || holdTake)) begin
      v1Valid_q <= 1'b1;
      v1Chan_q  <= chanNow;
      v1_q      <= ctrl_q.doubleSamplingSelect
                   ? 32'(videoLevel) - 32'(resetLevel)
                   : 32'(videoLevel) - 32'(refLevel);
    end else if (holdTake) begin
      v1Valid_q <= 1'b0;
    end
  end

  // Stage two: coded word waiting for the FIFO
  always_ff @(posedge core_clk) begin
    if (rst) begin
      holdValid_q <= 1'b0;
      hold_q      <= '0;
    end else if (holdTake) begin
      holdValid_q    <= 1'b1;
      hold_q.channel <= v1Chan_q;
      hold_q.code    <= codeOf(v1_q,
                               chanByte(offsetCodes_q, v1Chan_q),
                               chanByte(gainCodes_q, v1Chan_q),
                               ctrl_q.blackLevelPlacement,
                               ctrl_q.outputPolarityInvert);
    end else if (fifoReady) begin
      holdValid_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lastCode_q <= 16'h0000;
    end else if (holdValid_q && fifoReady) begin
      lastCode_q <= hold_q.code;
    end
  end

  ccoc_word_type fifoOut;

  ccoc_fifo #(
    .WIDTH (WordW),
    .DEPTH (DepthWords)
  ) u_fifo (
    .core_clk (core_clk),
    .rst      (rst),
    .inValid  (holdValid_q),
    .inReady  (fifoReady),
    .inData   (hold_q),
    .outValid (outValid),
    .outReady (outReady),
    .outData  (fifoOut)
  );

  assign outCode    = fifoOut.code;
  assign outChannel = fifoOut.channel;

  // AHB-Lite slave, zero wait states
  logic       wrPend_q;
  logic [7:0] wrAddr_q;
  logic       addrPhase;
  logic       overrunSet;
  logic       overrunClr;

  assign addrPhase  = hsel && htrans[1] && hready;
  assign overrunSet = sampleStrobe && v1Valid_q && !holdTake;
  assign overrunClr = wrPend_q && (wrAddr_q == AddrStatus)
                      && hwdata[StOverrun];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end else begin
      wrPend_q <= addrPhase && hwrite;
      if (addrPhase) wrAddr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q        <= CtrlReset;
      offsetCodes_q <= OffsetReset;
      gainCodes_q   <= GainReset;
    end else if (wrPend_q) begin
      unique case (wrAddr_q)
        AddrCtrl:   ctrl_q        <= hwdata[CtrlW-1:0];
        AddrOffset: offsetCodes_q <= hwdata[23:0];
        AddrGain:   gainCodes_q   <= hwdata[23:0];
        default:    ;
      endcase
    end
  end

  // Sticky overrun; a new overrun wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      overrun_q <= 1'b0;
    end else if (overrunSet) begin
      overrun_q <= 1'b1;
    end else if (overrunClr) begin
      overrun_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addrPhase && !hwrite) begin
        unique case (haddr[7:0])
          AddrCtrl:   hrdata <= {{(32-CtrlW){1'b0}}, ctrl_q};
          AddrOffset: hrdata <= {8'h00, offsetCodes_q};
          AddrGain:   hrdata <= {8'h00, gainCodes_q};
          AddrStatus: hrdata <= {27'h000_0000, holdValid_q, clampArmed_q,
                                 chanNow, overrun_q};
          AddrLast:   hrdata <= {16'h0000, lastCode_q};
          default:    hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : clamp_control_and_output_coding

`default_nettype wire

/* File: tb/ccoc_scan_timing.sv */
// Behavioural scanner timing source: pixel sync pulse and clamp pin
`timescale 1ns/10ps
`default_nettype none
module ccoc_scan_timing (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic go,
  input  wire logic clampLevel,
  output logic      pixelSampleSync,
  output logic      clampOrCyclePin
);
  // Pin level is held across the pulse, then flipped so stale levels show
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pixelSampleSync <= 1'b0;
      clampOrCyclePin <= 1'b0;
    end else begin
      pixelSampleSync <= go;
      if (go)
        clampOrCyclePin <= clampLevel;
      else if (pixelSampleSync)
        clampOrCyclePin <= ~clampOrCyclePin;
    end
  end
endmodule : ccoc_scan_timing
`default_nettype wire

/* File: tb/ccoc_checker_sva.sv */
// Concurrent checks on the clamp control and output coding ports
`timescale 1ns/10ps
`default_nettype none
module ccoc_checker
  import ccoc_pkg::*;
#(
  parameter int StepNarrowUv = 100000,
  parameter int StepWideUv   = 200000,
  parameter int BotNarrowUv  = 400000,
  parameter int BotWideUv    = 300000
) (
  input wire logic               core_clk,
  input wire logic               rst,
  input wire logic               pixelSampleSync,
  input wire logic               clampPulse,
  input wire logic               resetSampleStrobe,
  input wire logic               clampLevelDacEnable,
  input wire logic signed [23:0] clampLevelDacUv,
  input wire logic [1:0]         activeChannel,
  input wire logic               outValid,
  input wire logic               outReady,
  input wire logic [15:0]        outCode,
  input wire logic [1:0]         outChannel
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic [4:0] syncAge_q;
  int         offN;
  int         offW;
  logic       dacOk;

  // Cycles since the last pixel sync pulse, saturating
  always_ff @(posedge core_clk) begin
    if (rst)
      syncAge_q <= 5'h1F;
    else if (pixelSampleSync)
      syncAge_q <= 5'h00;
    else if (syncAge_q != 5'h1F)
      syncAge_q <= syncAge_q + 5'h01;
  end

  always_comb begin
    offN = int'(clampLevelDacUv) - BotNarrowUv;
    offW = int'(clampLevelDacUv) - BotWideUv;
    dacOk = (offN >= 0 && offN <= 15 * StepNarrowUv
             && offN % StepNarrowUv == 0)
         || (offW >= 0 && offW <= 15 * StepWideUv && offW % StepWideUv == 0);
  end

  clamp_single_a: assert property (clampPulse |=> !clampPulse)
    else $error("clamp pulse wider than one cycle");
  strobe_single_a: assert property (
    resetSampleStrobe |=> !resetSampleStrobe)
    else $error("reset sample strobe wider than one cycle");
  clamp_on_strobe_a: assert property (
    clampPulse |-> resetSampleStrobe)
    else $error("clamp pulse away from strobe position");
  strobe_cause_a: assert property (
    resetSampleStrobe |-> syncAge_q inside {[2:16]})
    else $error("strobe without a recent pixel sync");
  dac_off_zero_a: assert property (
    !clampLevelDacEnable |-> clampLevelDacUv == 24'sd0)
    else $error("disabled clamp DAC shows a level");
  dac_level_a: assert property (clampLevelDacEnable |-> dacOk)
    else $error("clamp DAC level off its step grid");
  word_hold_a: assert property (
    outValid && !outReady |=> outValid && $stable(outCode)
    && $stable(outChannel))
    else $error("output word changed while stalled");
  out_chan_a: assert property (outValid |-> outChannel != 2'h3)
    else $error("output word with illegal channel");
  active_chan_a: assert property (activeChannel != 2'h3)
    else $error("illegal active channel");

  clamp_seen_c: cover property (clampPulse);
  word_moved_c: cover property (outValid && outReady);
  stall_c: cover property (outValid && !outReady [*3]);
endmodule : ccoc_checker

bind clamp_control_and_output_coding ccoc_checker #(
  .StepNarrowUv(StepNarrowUv), .StepWideUv(StepWideUv),
  .BotNarrowUv(BotNarrowUv), .BotWideUv(BotWideUv)
) u_ccocChk (
  .core_clk(core_clk), .rst(rst), .pixelSampleSync(pixelSampleSync),
  .clampPulse(clampPulse), .resetSampleStrobe(resetSampleStrobe),
  .clampLevelDacEnable(clampLevelDacEnable),
  .clampLevelDacUv(clampLevelDacUv), .activeChannel(activeChannel),
  .outValid(outValid), .outReady(outReady), .outCode(outCode),
  .outChannel(outChannel)
);
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the clamp control and output coding block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import ccoc_pkg::*;
;
  localparam int StepN = 100000;
  localparam int StepW = 200000;
  localparam int BotN  = 400000;
  localparam int BotW  = 300000;

  logic               core_clk = 1'b0;
  logic               rst = 1'b1;
  logic               go = 1'b0;
  logic               clampLevel = 1'b0;
  logic               pixelSampleSync, clampOrCyclePin;
  logic signed [23:0] videoLevel = 24'sd0;
  logic signed [23:0] resetLevel = 24'sd0;
  logic signed [23:0] referenceLevelPin = 24'sd0;
  logic               clampPulse, resetSampleStrobe, clampLevelDacEnable;
  logic signed [23:0] clampLevelDacUv;
  logic [1:0]         activeChannel, outChannel;
  logic               outValid, hreadyout, hresp;
  logic               outReady = 1'b1;
  logic [15:0]        outCode;
  logic               hsel = 1'b0;
  logic               hwrite = 1'b0;
  logic [31:0]        haddr = 32'h0000_0000;
  logic [31:0]        hwdata = 32'h0000_0000;
  logic [31:0]        hrdata;
  logic [1:0]         htrans = 2'h0;
  wire logic          hready;
  logic [17:0]        q[$];
  logic               clampSeen;
  int                 lastDelay, badCount, nTests;
  int                 dly[4];

  assign hready = hreadyout;
  always #10 core_clk = ~core_clk;

  ccoc_scan_timing u_scan (.core_clk(core_clk), .rst(rst), .go(go),
    .clampLevel(clampLevel), .pixelSampleSync(pixelSampleSync),
    .clampOrCyclePin(clampOrCyclePin));

  clamp_control_and_output_coding #(.StepNarrowUv(StepN),
    .StepWideUv(StepW), .BotNarrowUv(BotN), .BotWideUv(BotW)) dut (
    .core_clk(core_clk), .rst(rst), .pixelSampleSync(pixelSampleSync),
    .clampOrCyclePin(clampOrCyclePin), .videoLevel(videoLevel),
    .resetLevel(resetLevel), .referenceLevelPin(referenceLevelPin),
    .clampPulse(clampPulse), .resetSampleStrobe(resetSampleStrobe),
    .clampLevelDacEnable(clampLevelDacEnable),
    .clampLevelDacUv(clampLevelDacUv), .activeChannel(activeChannel),
    .outValid(outValid), .outReady(outReady), .outCode(outCode),
    .outChannel(outChannel), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

  // Words move at the next rising edge when both sides are high
  always @(negedge core_clk)
    if (outValid === 1'b1 && outReady === 1'b1)
      q.push_back({outChannel, outCode});

  task automatic testDone;
    $display("Comparisons %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : testDone

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic waitRdy;
    int n = 0;
    @(posedge core_clk);
    while (hready !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 50) begin
      badCount++;
      testDone();
    end
  endtask : waitRdy

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    r = hrdata;
    check(32'(hresp), 32'h0000_0000);
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    ahb(1'b0, a, 32'h0000_0000, r);
  endtask : rd

  task automatic pixel(input int vin, input int vres, input logic cl);
    videoLevel <= 24'(vin);
    resetLevel <= 24'(vres);
    clampLevel <= cl;
    go <= 1'b1;
    q.delete();
    clampSeen = 1'b0;
    lastDelay = 0;
    @(posedge core_clk);
    go <= 1'b0;
    for (int n = 1; n < 20; n++) begin
      @(negedge core_clk);
      if (clampPulse === 1'b1)
        clampSeen = 1'b1;
      if (resetSampleStrobe === 1'b1)
        lastDelay = n;
    end
    @(posedge core_clk);
  endtask : pixel

  task automatic take(input logic [15:0] code, input logic [1:0] ch);
    for (int n = 0; n < 50 && q.size() == 0; n++)
      @(posedge core_clk);
    if (q.size() == 0) begin
      badCount++;
      testDone();
    end
    check({14'h0, q.pop_front()}, {14'h0, ch, code});
  endtask : take

  // Expected code from the gained level in microvolts
  function automatic logic [15:0] expc(input longint v3, input int pl,
                                       input int inv);
    longint d;
    d = v3 * 65535 / 3000000;
    if (2'(pl) == PlaceNegative)
      d = d + 65535;
    else if (2'(pl) != PlacePositive)
      d = d + 32767;
    if (d < 0)
      d = 0;
    if (d > 65535)
      d = 65535;
    if (inv != 0)
      d = 65535 - d;
    return 16'(d);
  endfunction : expc

  initial begin
    repeat (100000) @(posedge core_clk);
    badCount++;
    testDone();
  end

  initial begin
    logic [31:0] r;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(AddrCtrl, r);
    check(r, 32'h0000_0001);
    rd(AddrOffset, r);
    check(r, 32'h0080_8080);
    rd(AddrGain, r);
    check(r, 32'h0000_0000);
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14, r);
    check(r, 32'h0000_0000);
    check(32'(clampLevelDacEnable), 1);
    check(32'(clampLevelDacUv), BotN);
    // Offset +260 mV on red/green, -260 mV on blue; gain 1, 2, 1
    wr(AddrOffset, 32'h0000_FFFF);
    wr(AddrGain, 32'h004B_B34B);
    rd(AddrGain, r);
    check(r, 32'h004B_B34B);
    $display("registers done");
    for (int i = 0; i < 8; i++) begin
      wr(AddrCtrl, 32'(1 | (i % 4) << 6 | (i / 4) << 8));
      pixel(340000, 0, 1'b0);
      take(expc(600000, i % 4, i / 4), 2'h0);
    end
    wr(AddrCtrl, 32'(1 | 3 << 6 | 1 << 14));
    pixel(340000, 0, 1'b0);
    take(expc(1200000, 3, 0), 2'h1);
    wr(AddrCtrl, 32'(1 | 3 << 6 | 2 << 14));
    pixel(-340000, 0, 1'b0);
    take(16'h0000, 2'h2);
    wr(AddrCtrl, 32'(1 | 2 << 6 | 2 << 14));
    pixel(-340000, 0, 1'b0);
    take(expc(-600000, 2, 0), 2'h2);
    $display("coding done");
    wr(AddrCtrl, 32'(3 << 6 | 2 << 16));
    pixel(BotN + 2 * StepN + 340000, 12345, 1'b0);
    check(32'(clampLevelDacUv), BotN + 2 * StepN);
    take(expc(600000, 3, 0), 2'h0);
    wr(AddrCtrl, 32'(4 | 3 << 6 | 1 << 16));
    pixel(BotW + StepW + 340000, 12345, 1'b0);
    check(32'(clampLevelDacUv), BotW + StepW);
    take(expc(600000, 3, 0), 2'h0);
    referenceLevelPin <= 24'sd777000;
    wr(AddrCtrl, 32'(2 | 3 << 6));
    pixel(1117000, 12345, 1'b0);
    check(32'(clampLevelDacEnable), 0);
    take(expc(600000, 3, 0), 2'h0);
    $display("reference done");
    for (int p = 0; p < 4; p++) begin
      wr(AddrCtrl, 32'(1 | p << 4 | 3 << 6));
      pixel(340000, 0, 1'b1);
      check(32'(clampSeen), 1);
      dly[p] = lastDelay;
      check(dly[p] - dly[0], p);
    end
    pixel(340000, 0, 1'b0);
    check(32'(clampSeen), 0);
    wr(AddrCtrl, 32'(1 | 1 << 3 | 3 << 6 | 1 << 9 | 1 << 11));
    pixel(340000, 0, 1'b0);
    check(32'(clampSeen), 1);
    wr(AddrCtrl, 32'(1 | 3 << 6 | 1 << 9 | 1 << 11));
    pixel(340000, 0, 1'b1);
    check(32'(clampSeen), 0);
    wr(AddrCtrl, 32'(1 | 3 << 6 | 1 << 9 | 1 << 10 | 1 << 11));
    for (int k = 1; k < 4; k++) begin
      pixel(340000, 0, 1'b1);
      check(32'(activeChannel), k % 3);
    end
    wr(AddrCtrl, 32'(1 | 3 << 6 | 1 << 9 | 2 << 12));
    pixel(340000, 0, 1'b0);
    take(expc(80000, 3, 0), 2'h2);
    $display("clamp and cycle done");
    wr(AddrCtrl, 32'(1 | 3 << 6));
    outReady <= 1'b0;
    repeat (22) pixel(340000, 0, 1'b0);
    rd(AddrStatus, r);
    check(32'(r[StOverrun]), 1);
    wr(AddrStatus, 32'h0000_0001);
    rd(AddrStatus, r);
    check(32'(r[StOverrun]), 0);
    outReady <= 1'b1;
    repeat (60) @(posedge core_clk);
    check(32'(q.size()), FifoDepth + 3);
    $display("buffer done");
    testDone();
  end
endmodule : tb_top
`default_nettype wire
